// *** mmer_params.svh ***
// constants of the management mode entry and resume unit
`ifndef MMER_PARAMS_SVH
`define MMER_PARAMS_SVH
`define MMER_ADDR_W 20
`define MMER_DATA_W 32
`define MMER_RAM_BASE 20'h38000
`define MMER_RAM_TOP 20'h3ffff
`define MMER_DUMP_TOP 20'h3ffff
`define MMER_DUMP_END 20'h3fe00
`define MMER_SLOT_FIRST 20'h3fffc
`define MMER_SLOT_LAST 20'h3ffa8
`define MMER_SLOT_STEP 20'h00004
`define MMER_SLOT_NUM 5'h16
`define MMER_SLOT_CR0 5'h00
`define MMER_SLOT_IP 5'h03
`define MMER_HALT_SLOT 20'h3ff02
`define MMER_IO_SLOT 20'h3ff00
`define MMER_REV_SLOT 20'h3fefc
`define MMER_IO_RESTART 8'hff
`define MMER_IO_NONE 8'h00
`define MMER_HALT_BIT 16
`define MMER_REV_IO_BIT 16
`define MMER_RSM_OPCODE 16'h0faa
`define MMER_EV_NUM 11
`define MMER_EV_MGMT 4
`define MMER_EV_NMI 8
`define MMER_EXC_MASK 11'h0ef
`define MMER_CR0_ENTRY_CLR 32'h8001000f
`define MMER_ENTRY_IP 32'h00008000
`endif

// *** mmer_pkg.sv ***
// types of the management mode entry and resume unit
package mmer_pkg;
    typedef enum logic [3:0] {
        MMER_IDLE, MMER_DRAIN, MMER_SAVE, MMER_SAVE_HALT, MMER_SAVE_IO,
        MMER_SAVE_REV, MMER_HANDLER, MMER_RD_ISSUE, MMER_RD_TAKE,
        MMER_RD_HALT, MMER_RD_IO, MMER_RD_IO_TAKE, MMER_DONE
    } mmer_state_e;
endpackage : mmer_pkg

// *** mmer_core.sv ***
// management mode entry, state save, resume and event ranking
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`include "mmer_params.svh"
// **********************************************************************
// Summary of operation
// - revision identifier bit 16 shows I/O restart
// - I/O slot 0FFH re-executes trapped I/O
// - entry clears I/O restart slot to 00H
// - every HALT sets control_reg_zero bit 16
// - halt bit copied to halt slot bit 0
// - halt slot bit 0 restarts HALT on resume
// - mode-active output low during state save
// - mgmt_ram fixed at 38000H to 3FFFFH
// - save area grows downward from 3FFFFH
// - registers in fixed 32-bit slots
// - opcode 0FAAH restores state then returns
// - resume outside mgmt_mode raises invalid opcode
// - mode-active output high when resume completes
// - events ranked one to eleven at boundaries
// - lower exceptions discarded then reissued, interrupts wait; only those dropped at a management entry are reissued
// - edge taken at boundary after bus drains
// - request needs inactive sample then active
// - nmi blocked until first handler completes
// - pipelined cycles stay correct around entry
// - request during mode held as one pending
// **********************************************************************
module mmer_core
    import mmer_pkg::*;
#(
    // arbitrary value, bit 16 is forced on regardless
    parameter logic [31:0] MGMT_REV_ID = 32'h0000_0a51
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic system_mgmt_interrupt_n,
    input wire logic instr_boundary,
    input wire logic [10:0] event_pending,
    input wire logic maskable_interrupt_request_enable,
    input wire logic shutdown,
    input wire logic bus_idle,
    input wire logic next_address_request_n,
    input wire logic halt_exec,
    input wire logic isr_done,
    input wire logic opcode_valid,
    input wire logic [15:0] opcode,
    input wire logic [31:0] save_data,
    input wire logic [19:0] core_addr,
    input wire logic [31:0] mem_rdata,
    output logic [19:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic mem_wr,
    output logic mem_rd,
    output logic [4:0] slot_idx,
    output logic [31:0] restore_data,
    output logic restore_we,
    output logic [10:0] service_grant,
    output logic [10:0] discard_exc,
    output logic invalid_opcode,
    output logic restart_io,
    output logic restart_halt,
    output logic resume_done,
    output logic halt_status,
    output logic mgmt_ram_hit,
    output logic mgmt_mode_active_n
);

    // ******************************************************************
    // helper functions
    // ******************************************************************
    function automatic logic [19:0] slot_addr(input logic [4:0] idx);
        logic [19:0] off;
        off = 20'(idx) * `MMER_SLOT_STEP;
        slot_addr = `MMER_SLOT_FIRST - off;
    endfunction : slot_addr

    function automatic logic in_ram(input logic [19:0] a);
        in_ram = (a >= `MMER_RAM_BASE) && (a <= `MMER_RAM_TOP);
    endfunction : in_ram

    function automatic logic [10:0] top_one(input logic [10:0] v);
        logic [10:0] r;
        r = 11'h000;
        for (int i = `MMER_EV_NUM - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 11'h000;
                r[i] = 1'b1;
            end
        end
        top_one = r;
    endfunction : top_one

    mmer_state_e state_reg;
    logic smi_meta_reg;
    logic smi_sync_reg;
    logic smi_prev_reg;
    logic smi_pend_reg;
    logic active_reg;
    logic nmi_en_reg;
    logic halt_reg;
    logic [10:0] reissue_reg;
    logic [4:0] idx_reg;
    logic take_reg;
    logic halt_slot_reg;
    logic smi_edge;
    logic rsm_hit;
    logic [10:0] ev_mask;
    logic [10:0] ev_all;
    logic [10:0] grant;
    logic take_mgmt;
    logic last_slot;

    // ******************************************************************
    // request synchroniser and edge latch
    // ******************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            smi_meta_reg <= 1'b1;
            smi_sync_reg <= 1'b1;
            smi_prev_reg <= 1'b1;
        end else begin
            smi_meta_reg <= system_mgmt_interrupt_n;
            smi_sync_reg <= smi_meta_reg;
            smi_prev_reg <= smi_sync_reg;
        end
    end

    // inactive sample followed by active sample
    assign smi_edge = smi_prev_reg && !smi_sync_reg;

    // only one request can wait; further edges fold into it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            smi_pend_reg <= 1'b0;
        end else if (smi_edge) begin
            smi_pend_reg <= 1'b1;
        end else if (take_mgmt) begin
            smi_pend_reg <= 1'b0;
        end
    end

    // ******************************************************************
    // ranking at the instruction boundary
    // ******************************************************************
    always_comb begin
        // stored exceptions come back only once the mode has been left
        ev_all = event_pending | (active_reg ? 11'h000 : reissue_reg);
        ev_all[`MMER_EV_MGMT] = smi_pend_reg && !active_reg && !shutdown;
        ev_mask = 11'h7ff;
        ev_mask[`MMER_EV_NMI] = nmi_en_reg;
        ev_mask[`MMER_EV_NMI+1] = maskable_interrupt_request_enable;
        grant = instr_boundary && state_reg inside {MMER_IDLE, MMER_HANDLER}
            ? top_one(ev_all & ev_mask) : 11'h000;
    end

    assign take_mgmt = grant[`MMER_EV_MGMT];
    assign service_grant = grant;

    // exceptions below the winner drop now; only those dropped at a management entry come back at resume
    always_comb begin
        discard_exc = 11'h000;
        for (int i = 0; i < `MMER_EV_NUM; i++) begin
            if (grant != 11'h000 && grant < (11'h001 << i)) begin
                discard_exc[i] = ev_all[i];
            end
        end
        discard_exc = discard_exc & `MMER_EXC_MASK;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reissue_reg <= 11'h000;
        end else if (take_mgmt) begin
            reissue_reg <= discard_exc;
        end else begin
            reissue_reg <= reissue_reg & ~grant;
        end
    end

    // ******************************************************************
    // resume decode
    // ******************************************************************
    assign rsm_hit = opcode_valid && opcode == `MMER_RSM_OPCODE;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            invalid_opcode <= 1'b0;
        end else begin
            invalid_opcode <= rsm_hit && !active_reg;
        end
    end

    // ******************************************************************
    // sequencer
    // ******************************************************************
    assign last_slot = idx_reg == `MMER_SLOT_NUM - 5'h01;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= MMER_IDLE;
            idx_reg <= 5'h00;
            slot_idx <= 5'h00;
        end else begin
            unique case (state_reg)
                MMER_IDLE: begin
                    if (take_mgmt) begin
                        state_reg <= MMER_DRAIN;
                    end
                end
                // pipelined cycles issued with next address finish first
                MMER_DRAIN: begin
                    if (bus_idle && next_address_request_n) begin
                        state_reg <= MMER_SAVE;
                        idx_reg <= 5'h00;
                        slot_idx <= 5'h00;
                    end
                end
                MMER_SAVE: begin
                    idx_reg <= idx_reg + 5'h01;
                    slot_idx <= idx_reg + 5'h01;
                    if (last_slot) begin
                        state_reg <= MMER_SAVE_HALT;
                    end
                end
                MMER_SAVE_HALT: state_reg <= MMER_SAVE_IO;
                MMER_SAVE_IO: state_reg <= MMER_SAVE_REV;
                MMER_SAVE_REV: state_reg <= MMER_HANDLER;
                MMER_HANDLER: begin
                    if (rsm_hit) begin
                        state_reg <= MMER_RD_ISSUE;
                        idx_reg <= 5'h00;
                    end
                end
                MMER_RD_ISSUE: state_reg <= MMER_RD_TAKE;
                MMER_RD_TAKE: begin
                    idx_reg <= idx_reg + 5'h01;
                    slot_idx <= idx_reg; // names the load two cycles on
                    state_reg <= last_slot ? MMER_RD_HALT : MMER_RD_ISSUE;
                end
                MMER_RD_HALT: state_reg <= MMER_RD_IO;
                MMER_RD_IO: state_reg <= MMER_RD_IO_TAKE;
                MMER_RD_IO_TAKE: state_reg <= MMER_DONE;
                MMER_DONE: state_reg <= MMER_IDLE;
            endcase
        end
    end

    // ******************************************************************
    // mode active output
    // ******************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
        end else if (state_reg == MMER_DRAIN && bus_idle &&
                next_address_request_n) begin
            active_reg <= 1'b1;
        end else if (state_reg == MMER_DONE) begin
            active_reg <= 1'b0;
        end
    end

    assign mgmt_mode_active_n = !active_reg;
    assign mgmt_ram_hit = active_reg && in_ram(core_addr);

    // ******************************************************************
    // halt status and nmi gate
    // ******************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            halt_reg <= 1'b0;
        end else if (halt_exec) begin
            halt_reg <= 1'b1;
        end else if (state_reg == MMER_SAVE_REV) begin
            halt_reg <= 1'b0;
        end else if (restore_we && slot_idx == `MMER_SLOT_CR0) begin
            halt_reg <= restore_data[`MMER_HALT_BIT];
        end
    end

    assign halt_status = halt_reg;

    // no nmi through save, handler or resume until a handler returns
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            nmi_en_reg <= 1'b1;
        end else if (take_mgmt) begin
            nmi_en_reg <= 1'b0;
        end else if (isr_done && state_reg == MMER_HANDLER) begin
            nmi_en_reg <= 1'b1;
        end else if (state_reg == MMER_DONE) begin
            nmi_en_reg <= 1'b1;
        end
    end

    // ******************************************************************
    // save area port
    // ******************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mem_addr <= 20'h00000;
            mem_wdata <= 32'h0000_0000;
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
        end else begin
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            unique case (state_reg)
                MMER_SAVE: begin
                    mem_addr <= slot_addr(idx_reg);
                    mem_wdata <= save_data;
                    if (idx_reg == `MMER_SLOT_CR0) begin
                        mem_wdata[`MMER_HALT_BIT] <= halt_reg;
                    end
                    mem_wr <= 1'b1;
                end
                MMER_SAVE_HALT: begin
                    mem_addr <= `MMER_HALT_SLOT;
                    mem_wdata <= {31'h0000_0000, halt_reg};
                    mem_wr <= 1'b1;
                end
                MMER_SAVE_IO: begin
                    mem_addr <= `MMER_IO_SLOT;
                    mem_wdata <= {24'h00_0000, `MMER_IO_NONE};
                    mem_wr <= 1'b1;
                end
                MMER_SAVE_REV: begin
                    mem_addr <= `MMER_REV_SLOT;
                    mem_wdata <= MGMT_REV_ID |
                        (32'h0000_0001 << `MMER_REV_IO_BIT);
                    mem_wr <= 1'b1;
                end
                MMER_RD_ISSUE: begin
                    mem_addr <= slot_addr(idx_reg);
                    mem_rd <= 1'b1;
                end
                MMER_RD_HALT: begin
                    mem_addr <= `MMER_HALT_SLOT;
                    mem_rd <= 1'b1;
                end
                MMER_RD_IO: begin
                    mem_addr <= `MMER_IO_SLOT;
                    mem_rd <= 1'b1;
                end
                default: begin
                    mem_addr <= mem_addr;
                end
            endcase
        end
    end

    // ******************************************************************
    // core register load and restart slots
    // ******************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            restore_data <= 32'h0000_0000;
            restore_we <= 1'b0;
            take_reg <= 1'b0;
        end else begin
            // read data stands the cycle after the strobe, so load late
            take_reg <= state_reg == MMER_RD_TAKE;
            restore_we <= take_reg;
            if (take_reg) begin
                restore_data <= mem_rdata;
            end else if (state_reg == MMER_SAVE_REV) begin
                // handler entry point is put on restore_data, with restore_we left low
                restore_data <= `MMER_ENTRY_IP;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            halt_slot_reg <= 1'b0;
        end else if (state_reg == MMER_RD_IO_TAKE) begin
            halt_slot_reg <= mem_rdata[0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            restart_io <= 1'b0;
            restart_halt <= 1'b0;
            resume_done <= 1'b0;
        end else begin
            resume_done <= state_reg == MMER_DONE;
            // io slot data stands in the done cycle itself
            restart_io <= state_reg == MMER_DONE &&
                mem_rdata[7:0] == `MMER_IO_RESTART;
            restart_halt <= state_reg == MMER_DONE && halt_slot_reg;
        end
    end

endmodule : mmer_core

// *** mmer_props.sv ***
// assertions on the management mode entry and resume unit
`timescale 1ns/1ns
`include "mmer_params.svh"
module mmer_props (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic opcode_valid,
    input wire logic [15:0] opcode,
    input wire logic [10:0] event_pending,
    input wire logic [19:0] core_addr,
    input wire logic [19:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [4:0] slot_idx,
    input wire logic [31:0] restore_data,
    input wire logic restore_we,
    input wire logic [10:0] service_grant,
    input wire logic invalid_opcode,
    input wire logic resume_done,
    input wire logic mgmt_ram_hit,
    input wire logic mgmt_mode_active_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // halt bit as it went out in the control word
    logic cr0_halt_reg;
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            cr0_halt_reg <= 1'b0;
        else if (mem_wr && mem_addr == 20'h3fffc)
            cr0_halt_reg <= mem_wdata[16];
    end
    sequence s_save_go;
        $fell(mgmt_mode_active_n);
    endsequence
    sequence s_resume_go;
        opcode_valid && opcode == 16'h0faa && !mgmt_mode_active_n;
    endsequence
    a_save_start: assert property (s_save_go |-> ##[0:2]
        (mem_wr && mem_addr == 20'h3fffc))
        else $error("save did not begin at top slot");
    a_save_stride: assert property (mem_wr && mem_addr > 20'h3ffa8
        && mem_addr <= 20'h3fffc |=> mem_wr
        && mem_addr == $past(mem_addr) - 20'h4)
        else $error("save slots not consecutive");
    a_io_clear: assert property (mem_wr && mem_addr == 20'h3ff00
        |-> mem_wdata[7:0] == 8'h00)
        else $error("io restart slot not cleared");
    a_rev_bit: assert property (mem_wr && mem_addr == 20'h3fefc
        |-> mem_wdata[16])
        else $error("revision word lacks io restart bit");
    a_halt_copy: assert property (mem_wr && mem_addr == 20'h3ff02
        |-> mem_wdata[0] == cr0_halt_reg)
        else $error("halt slot differs from control word");
    a_wr_active: assert property (mem_wr |-> !mgmt_mode_active_n)
        else $error("save write outside active mode");
    a_rd_active: assert property (mem_rd |-> !mgmt_mode_active_n)
        else $error("restore read outside active mode");
    a_restore_halt: assert property (restore_we && slot_idx == 5'h00
        |-> restore_data[16] == cr0_halt_reg)
        else $error("control word restored from wrong slot");
    a_bad_resume: assert property (opcode_valid && opcode == 16'h0faa
        && mgmt_mode_active_n |=> invalid_opcode)
        else $error("resume outside mode not refused");
    a_resume_end: assert property (resume_done |->
        $rose(mgmt_mode_active_n))
        else $error("active output not released at resume");
    a_resume_flow: assert property (s_resume_go |-> ##[1:100]
        resume_done)
        else $error("resume did not complete");
    a_rank_order: assert property (service_grant != 11'h0 |->
        $onehot(service_grant) && ((service_grant - 11'h1)
        & event_pending & `MMER_EXC_MASK) == 11'h0)
        else $error("grant skipped a higher exception");
    a_ram_range: assert property (mgmt_ram_hit |->
        core_addr >= 20'h38000 && core_addr <= 20'h3ffff)
        else $error("ram hit outside fixed range");
endmodule : mmer_props

// *** mmer_mem_model.sv ***
// save area memory on the far side of the core
`timescale 1ns/1ns
module mmer_mem_model (
    input wire logic sys_clk,
    input wire logic [19:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [logic [19:0]];
    int n_wr = 0;
    initial mem_rdata = 32'h0;
    // data valid one cycle after the strobe only; toggles otherwise
    always @(posedge sys_clk) begin
        if (mem_wr) begin
            mem[mem_addr] = mem_wdata;
            n_wr++;
        end
        if (mem_rd)
            mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
        else
            mem_rdata <= ~mem_rdata;
    end
    task automatic poke(input logic [19:0] a, input logic [31:0] d);
        mem[a] = d;
    endtask : poke
endmodule : mmer_mem_model

// *** tb.sv ***
// self-checking bench for the management mode entry and resume unit
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [10:0] pend;
        logic ie;
        logic [10:0] grant;
        logic [10:0] disc;
    } mmer_row_s;
    // ************************************************************
    // signals
    // ************************************************************
    logic sys_clk = 1'b0, rst_n = 1'b0;
    logic system_mgmt_interrupt_n = 1'b1;
    logic instr_boundary = 1'b0, maskable_interrupt_request_enable = 1'b0, shutdown = 1'b0;
    logic bus_idle = 1'b1, next_address_request_n = 1'b1;
    logic halt_exec = 1'b0, isr_done = 1'b0, opcode_valid = 1'b0;
    logic [10:0] event_pending = 11'h0;
    logic [15:0] opcode = 16'h0;
    logic [31:0] save_data = 32'h5a5a4a4a;
    logic [19:0] core_addr = 20'h0;
    logic [31:0] mem_rdata, mem_wdata, restore_data;
    logic [19:0] mem_addr;
    logic mem_wr, mem_rd, restore_we, invalid_opcode, restart_io;
    logic restart_halt, resume_done, halt_status, mgmt_ram_hit;
    logic mgmt_mode_active_n;
    logic [4:0] slot_idx;
    logic [10:0] service_grant, discard_exc;
    int n_mismatch = 0, checks_done = 0;
    // bit 4 stays ignored; only the last row discards, and no row takes
    // the management event, so nothing discarded here is stored
    mmer_row_s rows [6] = '{
        '{11'h010, 1'b1, 11'h000, 11'h000},
        '{11'h401, 1'b1, 11'h001, 11'h000},
        '{11'h300, 1'b1, 11'h100, 11'h000},
        '{11'h200, 1'b1, 11'h200, 11'h000},
        '{11'h600, 1'b0, 11'h400, 11'h000},
        '{11'h0e8, 1'b1, 11'h008, 11'h0e0}};
    mmer_core i_dut (.*);
    mmer_mem_model i_mem (.*);
    always #25 sys_clk = ~sys_clk;
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // k 0: wait for active output low, k 1: wait for resume pulse
    task automatic wait_on(input int k);
        int i;
        i = 0;
        while ((k == 0 ? mgmt_mode_active_n !== 1'b0
                : resume_done !== 1'b1) && i < 200) begin
            @(negedge sys_clk);
            i++;
        end
        if (i == 200) begin
            n_mismatch++;
            complete_run();
        end
    endtask : wait_on
    task automatic resume(input logic io, input logic hlt);
        opcode_valid <= 1'b1;
        opcode <= 16'h0faa;
        @(posedge sys_clk);
        opcode_valid <= 1'b0;
        wait_on(1);
        check_val(restart_io, io);
        check_val(restart_halt, hlt);
        check_val(mgmt_mode_active_n, 1);
        $display("test resume done");
    endtask : resume
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        tick(10);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check_val(mgmt_mode_active_n, 1);
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge sys_clk);
            instr_boundary <= 1'b1;
            event_pending <= rows[i].pend;
            maskable_interrupt_request_enable <= rows[i].ie;
            @(negedge sys_clk);
            check_val(service_grant, rows[i].grant);
            check_val(discard_exc, rows[i].disc);
        end
        @(posedge sys_clk);
        instr_boundary <= 1'b0;
        event_pending <= 11'h0;
        opcode_valid <= 1'b1;
        opcode <= 16'h0faa;
        @(posedge sys_clk);
        opcode_valid <= 1'b0;
        @(negedge sys_clk);
        check_val(invalid_opcode, 1);
        $display("test rank and opcode done");
        i_mem.poke(20'h3ff00, 32'h000000ff);
        @(posedge sys_clk);
        halt_exec <= 1'b1;
        bus_idle <= 1'b0;
        next_address_request_n <= 1'b0;
        @(posedge sys_clk);
        halt_exec <= 1'b0;
        // no reset is applied from here to the end of the save
        system_mgmt_interrupt_n <= 1'b0;
        instr_boundary <= 1'b1;
        tick(8);
        instr_boundary <= 1'b0;
        @(negedge sys_clk);
        check_val(halt_status, 1);
        check_val(mgmt_mode_active_n, 1);
        @(posedge sys_clk);
        bus_idle <= 1'b1;
        next_address_request_n <= 1'b1;
        wait_on(0);
        tick(40);
        check_val(i_mem.n_wr, 25);
        check_val(i_mem.mem[20'h3fffc][16], 1);
        check_val(i_mem.mem[20'h3ff02][0], 1);
        check_val(i_mem.mem[20'h3ff00], 0);
        check_val(i_mem.mem[20'h3fefc][16], 1);
        check_val(i_mem.mem[20'h3ffa8], save_data);
        check_val(i_mem.mem[20'h3fff0], save_data);
        $display("test entry done");
        system_mgmt_interrupt_n <= 1'b1;
        core_addr <= 20'h38000;
        instr_boundary <= 1'b1;
        event_pending <= 11'h100;
        @(negedge sys_clk);
        check_val(service_grant, 11'h000);
        check_val(mgmt_ram_hit, 1);
        @(posedge sys_clk);
        instr_boundary <= 1'b0;
        isr_done <= 1'b1;
        tick(1);
        isr_done <= 1'b0;
        instr_boundary <= 1'b1;
        @(negedge sys_clk);
        check_val(service_grant, 11'h100);
        @(posedge sys_clk);
        instr_boundary <= 1'b0;
        event_pending <= 11'h000;
        tick(2);
        system_mgmt_interrupt_n <= 1'b0;
        i_mem.poke(20'h3ff00, 32'h000000ff);
        tick(4);
        resume(1'b1, 1'b1);
        check_val(halt_status, 1);
        @(posedge sys_clk);
        instr_boundary <= 1'b1;
        event_pending <= 11'h020;
        wait_on(0);
        check_val(mgmt_mode_active_n, 0);
        @(posedge sys_clk);
        event_pending <= 11'h000;
        tick(39);
        instr_boundary <= 1'b0;
        i_mem.poke(20'h3ff02, 32'h0);
        resume(1'b0, 1'b0);
        @(posedge sys_clk);
        instr_boundary <= 1'b1;
        @(negedge sys_clk);
        check_val(service_grant, 11'h020);
        @(posedge sys_clk);
        @(negedge sys_clk);
        check_val(service_grant, 11'h000);
        @(posedge sys_clk);
        instr_boundary <= 1'b0;
        system_mgmt_interrupt_n <= 1'b1;
        $display("test reissue done");
        tick(5);
        complete_run();
    end
endmodule : tb
bind mmer_core mmer_props i_props (.*);
